/* File: src/gpp_pkg.sv */
// Package for the general purpose port slice: register map, reset values,
// pin masks. Assumes a 32-bit APB slave with byte addresses.
package gpp_pkg;

   localparam int          NPIN        = 6;
   localparam int          PIN_THREE   = 3;

   // Register byte offsets
   localparam logic [7:0]  OFF_PIN     = 8'h00;
   localparam logic [7:0]  OFF_LAT     = 8'h04;
   localparam logic [7:0]  OFF_DIR     = 8'h08;
   localparam logic [7:0]  OFF_ANSEL   = 8'h0C;
   localparam logic [7:0]  OFF_WPU     = 8'h10;
   localparam logic [7:0]  OFF_INLVL   = 8'h14;
   localparam logic [7:0]  OFF_SLEW    = 8'h18;
   localparam logic [7:0]  OFF_ODC     = 8'h1C;

   // Implemented bits: pin three has no latch, analog, slew or drain bit
   localparam logic [5:0]  IMPL_MASK   = 6'h37;
   localparam logic [5:0]  PIN3_MASK   = 6'h08;

   // Values after reset
   localparam logic [5:0]  RST_LAT     = 6'h00;
   localparam logic [5:0]  RST_DIR     = 6'h3F;
   localparam logic [5:0]  RST_ANSEL   = 6'h37;
   localparam logic [5:0]  RST_WPU     = 6'h00;
   localparam logic [5:0]  RST_INLVL   = 6'h3F;
   localparam logic [5:0]  RST_SLEW    = 6'h37;
   localparam logic [5:0]  RST_ODC     = 6'h00;

endpackage

/* File: src/gpp_cfg_if.sv */
// Interface between the port register block and its pin sampler.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface gpp_cfg_if;
   logic [5:0] ansel;
   logic [5:0] pin_q;
   logic       rpe;

   modport ctrl (output ansel, input pin_q, input rpe);
   modport samp (input ansel, output pin_q, output rpe);
endinterface : gpp_cfg_if

/* File: src/gpp_pad_sample.sv */
// Pin input sampler: synchronises pad levels and the reset-pin strap.
// Assumes pad inputs are asynchronous to pclk.
`timescale 1ns/1ns
module gpp_pad_sample
   import gpp_pkg::*;
(
   // Clock and reset
   input  wire logic            pclk,
   input  wire logic            presetn,
   // Pins
   input  wire logic [NPIN-1:0] pad_in,
   input  wire logic            reset_pin_enable,
   // Towards the register block
   gpp_cfg_if.samp              cf
);

   logic [NPIN-1:0] sync1_q;
   logic [NPIN-1:0] sync2_q;
   logic [NPIN-1:0] pin_q;
   logic            rpe1_q;
   logic            rpe2_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end else begin
         sync1_q <= pad_in;
         sync2_q <= sync1_q;
      end
   end

   // Analog pins have their input buffer off and read as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= 6'h00;
      end else begin
         pin_q <= sync2_q & ~cf.ansel; // R3 R12 R22
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rpe1_q <= 1'b0;
         rpe2_q <= 1'b0;
      end else begin
         rpe1_q <= reset_pin_enable;
         rpe2_q <= rpe1_q;
      end
   end

   assign cf.pin_q = pin_q;
   assign cf.rpe   = rpe2_q;

   property p_ana_zero;
      @(posedge pclk) disable iff (!presetn)
         1 |=> ((pin_q & $past(cf.ansel)) == 6'h00);
   endproperty
   a_ana_zero: assert property (p_ana_zero) // R12
      else $error("analog pin sampled as nonzero");

endmodule // gpp_pad_sample

/* File: src/gpp_port.sv */
// General purpose six-pin port: APB register block, output drive mux,
// pull-up, slew and threshold controls. Assumes pads resolve the wire
// from pad_out and pad_oe_n and peripherals share pclk.
`timescale 1ns/1ns

// Function
// R1: Writing the latch register and pin-level register does the same thing.
// R2: Latch register reads stored latch; pin-level register reads sampled pins.
// R3: Analog-select set turns off that pin's digital input buffer.
// R4: After reset each pin's output comes from the port latch.
// R5: Enabled analog output forces the digital driver off.
// R6: Peripheral-owned pin is not driven by the latch, still readable.
// R7: Six pins; direction one disables the driver, zero drives the latch.
// R8: Pin three is input only; its direction bit reads one always.
// R9: Pin-level write stores into the output latch, read-modify-write style.
// R10: Latch holds the latest value written through either register.
// R11: Direction bits still gate drivers on analog input pins.
// R12: Analog input pins read zero on every digital read.
// R13: Open-drain bit makes the pin sink only; clear gives push-pull.
// R14: An I2C-owned pin is open-drain regardless of the drain bit.
// R15: Slew-limit bit set limits slew; clear gives maximum slew.
// R16: Threshold bit chooses Schmitt CMOS or TTL input levels.
// R17: Software changes thresholds only while peripherals are disabled.
// R18: Analog-select does not affect digital output drive.
// R19: Analog-select resets to analog; software clears it for digital use.
// R20: Pin three pull-up is on when reset-pin enabled or its bit set.
// R21: Output pins lose pull-up unless open-drain and driving high.
// R22: Pin levels are registered on the clock before any read.
module gpp_port
   import gpp_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Pins
   input  wire logic [NPIN-1:0]   pad_in,
   output logic      [NPIN-1:0]   pad_out,
   output logic      [NPIN-1:0]   pad_oe_n,
   output logic      [NPIN-1:0]   pad_pullup,
   output logic      [NPIN-1:0]   pad_slew_limit,
   output logic      [NPIN-1:0]   pad_schmitt,
   input  wire logic              reset_pin_enable,
   // Peripheral functions
   input  wire logic [NPIN-1:0]   periph_en,
   input  wire logic [NPIN-1:0]   periph_out,
   input  wire logic [NPIN-1:0]   periph_od,
   input  wire logic [NPIN-1:0]   ana_out_en,
   output logic      [NPIN-1:0]   digital_in
);

   gpp_cfg_if cf ();

   logic [NPIN-1:0] lat_q;
   logic [NPIN-1:0] dir_q;
   logic [NPIN-1:0] ansel_q;
   logic [NPIN-1:0] wpu_q;
   logic [NPIN-1:0] inl_q;
   logic [NPIN-1:0] slr_q;
   logic [NPIN-1:0] odc_q;
   logic            pready_q;
   logic            pslverr_q;
   logic [31:0]     prdata_q;
   logic [NPIN-1:0] out_q;
   logic [NPIN-1:0] oe_n_q;
   logic [NPIN-1:0] pull_q;
   logic [NPIN-1:0] slew_q;
   logic [NPIN-1:0] schm_q;

   logic            acc;
   logic            wr_done;
   logic            mapped;
   logic [NPIN-1:0] pin_rd;
   logic [31:0]     rd_val;
   logic [NPIN-1:0] drv;
   logic [NPIN-1:0] od_eff;
   logic [NPIN-1:0] en;

   // Word-aligned hits inside the eight-register window
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0]        off);
      hit = (a == ADDR_W'(off));
   endfunction

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = hit(a, OFF_PIN)   || hit(a, OFF_LAT)   ||
                  hit(a, OFF_DIR)   || hit(a, OFF_ANSEL) ||
                  hit(a, OFF_WPU)   || hit(a, OFF_INLVL) ||
                  hit(a, OFF_SLEW)  || hit(a, OFF_ODC);
   endfunction

   gpp_pad_sample u_sample (
      .pclk             (pclk),
      .presetn          (presetn),
      .pad_in           (pad_in),
      .reset_pin_enable (reset_pin_enable),
      .cf               (cf.samp)
   );

   assign cf.ansel = ansel_q;

   // One wait state: the answer comes in the second access cycle
   assign acc     = psel & penable & ~pready_q;
   assign wr_done = psel & penable & pready_q & pwrite & ~pslverr_q;
   assign mapped  = is_mapped(paddr);

   // Pin three reads high while the pin serves as reset input
   always_comb begin
      pin_rd = cf.pin_q; // R2 R22
      if (cf.rpe) begin
         pin_rd[PIN_THREE] = 1'b1;
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit(paddr, OFF_PIN)) begin
         rd_val[NPIN-1:0] = pin_rd; // R2
      end else if (hit(paddr, OFF_LAT)) begin
         rd_val[NPIN-1:0] = lat_q & IMPL_MASK; // R2
      end else if (hit(paddr, OFF_DIR)) begin
         rd_val[NPIN-1:0] = dir_q | PIN3_MASK; // R8
      end else if (hit(paddr, OFF_ANSEL)) begin
         rd_val[NPIN-1:0] = ansel_q;
      end else if (hit(paddr, OFF_WPU)) begin
         rd_val[NPIN-1:0] = wpu_q;
      end else if (hit(paddr, OFF_INLVL)) begin
         rd_val[NPIN-1:0] = inl_q;
      end else if (hit(paddr, OFF_SLEW)) begin
         rd_val[NPIN-1:0] = slr_q;
      end else if (hit(paddr, OFF_ODC)) begin
         rd_val[NPIN-1:0] = odc_q;
      end
   end

   // APB handshake and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= acc;
         pslverr_q <= acc & ~mapped;
         if (acc && !pwrite) begin
            prdata_q <= rd_val;
         end
      end
   end

   // Both data registers land in the one latch; the pin view a master
   // reads first is what makes a bit-level update read-modify-write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_q <= RST_LAT; // R4
      end else if (wr_done && pstrb[0] &&
                   (hit(paddr, OFF_PIN) || hit(paddr, OFF_LAT))) begin
         lat_q <= pwdata[NPIN-1:0] & IMPL_MASK; // R1 R9 R10
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q <= RST_DIR;
      end else if (wr_done && pstrb[0] && hit(paddr, OFF_DIR)) begin
         dir_q <= pwdata[NPIN-1:0] | PIN3_MASK; // R8
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ansel_q <= RST_ANSEL; // R19
      end else if (wr_done && pstrb[0] && hit(paddr, OFF_ANSEL)) begin
         ansel_q <= pwdata[NPIN-1:0] & IMPL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wpu_q <= RST_WPU;
      end else if (wr_done && pstrb[0] && hit(paddr, OFF_WPU)) begin
         wpu_q <= pwdata[NPIN-1:0];
      end
   end

   // Threshold switching can glitch inputs; software owns the timing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inl_q <= RST_INLVL;
      end else if (wr_done && pstrb[0] && hit(paddr, OFF_INLVL)) begin
         inl_q <= pwdata[NPIN-1:0]; // R17
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slr_q <= RST_SLEW;
      end else if (wr_done && pstrb[0] && hit(paddr, OFF_SLEW)) begin
         slr_q <= pwdata[NPIN-1:0] & IMPL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         odc_q <= RST_ODC;
      end else if (wr_done && pstrb[0] && hit(paddr, OFF_ODC)) begin
         odc_q <= pwdata[NPIN-1:0] & IMPL_MASK;
      end
   end

   // Output source: peripheral over latch, analog output over both.
   // Analog-select is deliberately absent from the drive path.
   assign drv    = (periph_en & periph_out) | (~periph_en & lat_q); // R6
   assign od_eff = odc_q | (periph_en & periph_od); // R13 R14
   assign en     = ~dir_q & ~ana_out_en & ~PIN3_MASK; // R5 R7 R11 R18

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q  <= 6'h00;
         oe_n_q <= 6'h3F;
      end else begin
         out_q  <= drv;
         // Open-drain only drives while the value is low
         oe_n_q <= ~(en & (~od_eff | ~drv)); // R7 R13 R14
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pull_q <= 6'h00;
      end else begin
         pull_q <= ((~en & wpu_q) | (en & od_eff & drv)) // R21
                   | (cf.rpe ? PIN3_MASK : 6'h00); // R20
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slew_q <= RST_SLEW;
         schm_q <= RST_INLVL;
      end else begin
         slew_q <= slr_q; // R15
         schm_q <= inl_q; // R16
      end
   end

   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign pad_out        = out_q;
   assign pad_oe_n       = oe_n_q;
   assign pad_pullup     = pull_q;
   assign pad_slew_limit = slew_q;
   assign pad_schmitt    = schm_q;
   assign digital_in     = cf.pin_q; // R6

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_same_latch;
      (wr_done && pstrb[0] && (hit(paddr, OFF_PIN) || hit(paddr, OFF_LAT)))
         |=> (lat_q == ($past(pwdata[NPIN-1:0]) & IMPL_MASK));
   endproperty
   a_same_latch: assert property (p_same_latch) // R1
      else $error("data write did not reach the latch");

   property p_read_latch;
      (pready && !pwrite && !pslverr && hit(paddr, OFF_LAT))
         |-> (prdata == {26'h0, lat_q & IMPL_MASK});
   endproperty
   a_read_latch: assert property (p_read_latch) // R2
      else $error("latch read does not match latch");

   property p_ana_out;
      1 |=> ((pad_oe_n | ~$past(ana_out_en)) == 6'h3F);
   endproperty
   a_ana_out: assert property (p_ana_out) // R5
      else $error("pin driven while analog output enabled");

   property p_dir_in;
      1 |=> ((pad_oe_n | ~$past(dir_q)) == 6'h3F);
   endproperty
   a_dir_in: assert property (p_dir_in) // R7
      else $error("input pin is driven");

   property p_dir3_one;
      (pready && !pwrite && hit(paddr, OFF_DIR)) |-> prdata[PIN_THREE];
   endproperty
   a_dir3_one: assert property (p_dir3_one) // R8
      else $error("pin three direction read as zero");

   property p_i2c_od;
      1 |=> ((~pad_oe_n & $past(periph_en & periph_od & drv)) == 6'h00);
   endproperty
   a_i2c_od: assert property (p_i2c_od) // R14
      else $error("open-drain peripheral pin driven high");

   property p_pin3_pull;
      1 |=> (pad_pullup[PIN_THREE] ==
             $past(cf.rpe | wpu_q[PIN_THREE]));
   endproperty
   a_pin3_pull: assert property (p_pin3_pull) // R20
      else $error("pin three pull-up wrong");

   property p_pp_nopull;
      1 |=> ((pad_pullup & $past(en & ~od_eff)) == 6'h00);
   endproperty
   a_pp_nopull: assert property (p_pp_nopull) // R21
      else $error("pull-up on push-pull output");

   property p_periph_drive;
      1 |=> (((pad_out ^ $past(periph_out)) & $past(periph_en)) == 6'h00);
   endproperty
   a_periph_drive: assert property (p_periph_drive) // R6
      else $error("latch drives a peripheral-owned pin");

   // A refused or unrelated write must leave the latch alone
   property p_latch_hold;
      !(wr_done && pstrb[0] && (hit(paddr, OFF_PIN) || hit(paddr, OFF_LAT)))
         |=> $stable(lat_q);
   endproperty
   a_latch_hold: assert property (p_latch_hold) // R10
      else $error("latch changed without a data write");

   property p_pin_ana_zero;
      (pready && !pwrite && hit(paddr, OFF_PIN))
         |-> ((prdata[NPIN-1:0] & ansel_q) == 6'h00);
   endproperty
   a_pin_ana_zero: assert property (p_pin_ana_zero) // R12
      else $error("analog pin read back as nonzero");

   property p_unmapped_err;
      (pready && !mapped) |-> pslverr;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) // R2
      else $error("unmapped access answered without error");

   c_wr_pin:  cover property (wr_done && hit(paddr, OFF_PIN));
   c_rd_dir:  cover property (pready && !pwrite && hit(paddr, OFF_DIR));
   c_ana_out: cover property (|(ana_out_en & ~dir_q));
   c_i2c:     cover property (|(periph_en & periph_od & ~dir_q));
   c_pin3_rd: cover property (cf.rpe && pready && !pwrite &&
                              hit(paddr, OFF_PIN));

endmodule // gpp_port

/* File: bench/gpp_pad_model.sv */
// Pad wire model: resolves each pin from the port drive, an outside
// driver and the weak pull-up. Assumes oe_n low means the port drives.
`timescale 1ns/1ns
module gpp_pad_model
   import gpp_pkg::*;
(
   // Clock
   input  wire logic            pclk,
   // Port side
   input  wire logic [NPIN-1:0] pad_out,
   input  wire logic [NPIN-1:0] pad_oe_n,
   input  wire logic [NPIN-1:0] pad_pullup,
   // Outside driver
   input  wire logic [NPIN-1:0] ext_en,
   input  wire logic [NPIN-1:0] ext_val,
   // Resolved wire
   output logic      [NPIN-1:0] pad_in
);
   logic [NPIN-1:0] wander_q = 6'h15;

   // A floating pin wanders so a stale level never passes for a real one
   always @(posedge pclk) begin
      wander_q <= ~wander_q;
   end

   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         if (!pad_oe_n[i]) begin
            pad_in[i] = pad_out[i];
         end else if (ext_en[i]) begin
            pad_in[i] = ext_val[i];
         end else if (pad_pullup[i]) begin
            pad_in[i] = 1'b1;
         end else begin
            pad_in[i] = wander_q[i];
         end
      end
   end
endmodule // gpp_pad_model

/* File: bench/tb_top.sv */
// Self-checking bench for the six-pin port: APB master, pad model.
// Assumes one-wait-state APB slave and pin sampling within 3 edges.
`timescale 1ns/1ns
module tb_top;
   import gpp_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, strap, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  strb;
   logic        pready, pslverr;
   logic [5:0]  pad_in, pad_out, pad_oe_n, pad_pullup, slew, schm;
   logic [5:0]  p_en, p_out, p_od, a_out, din, ext_en, ext_val, v, a;
   integer      seed, err_total, n_tests, i;
   logic [7:0]  offs [7] = '{OFF_LAT, OFF_DIR, OFF_ANSEL, OFF_WPU,
                              OFF_INLVL, OFF_SLEW, OFF_ODC};
   logic [5:0]  rsts [7] = '{RST_LAT, RST_DIR, RST_ANSEL, RST_WPU,
                              RST_INLVL, RST_SLEW, RST_ODC};

   gpp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pullup(pad_pullup), .pad_slew_limit(slew), .pad_schmitt(schm),
      .reset_pin_enable(strap), .periph_en(p_en), .periph_out(p_out),
      .periph_od(p_od), .ana_out_en(a_out), .digital_in(din));
   gpp_pad_model pads (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val),
      .pad_in(pad_in));

   function automatic logic [5:0] pin_exp(input logic [5:0] e, an);
      return e & ~(an & IMPL_MASK);
   endfunction

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk6(input logic [5:0] got, exp);
      chk({26'h0, got}, {26'h0, exp});
   endtask
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      if (k == 16) chk(32'h0, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      settle(20000);
      err_total++;
      end_sim();
   end

   initial begin
      {psel, penable, pwrite, strap, paddr, pwdata} = '0;
      {p_en, p_out, p_od, a_out, ext_en, ext_val} = '0;
      strb = 4'hF;
      seed = 32'h5F3D;
      err_total = 0;
      n_tests = 0;
      presetn = 1'b0;
      settle(6);
      presetn <= 1'b1;
      chk6(pad_oe_n, 6'h3F);
      chk6(pad_out, 6'h00);
      chk6(slew, RST_SLEW);
      chk6(schm, RST_INLVL);
      for (i = 0; i < 7; i++) begin
         apb(1'b0, offs[i], 32'h0);
         chk(rd, {26'h0, rsts[i]});
      end
      // Latch written through both registers, read back as stored
      for (i = 0; i < 8; i++) begin
         v = 6'($random(seed));
         apb(1'b1, i[0] ? OFF_PIN : OFF_LAT, {26'h0, v});
         apb(1'b0, OFF_LAT, 32'h0);
         chk(rd, {26'h0, v & IMPL_MASK});
      end
      // Outputs with analog-select still set: drive on, reads zero
      ext_en <= PIN3_MASK;
      apb(1'b1, OFF_DIR, 32'h0);
      apb(1'b0, OFF_DIR, 32'h0);
      chk(rd, {26'h0, PIN3_MASK});
      settle(5);
      chk6(pad_oe_n, PIN3_MASK);
      chk6(pad_out & IMPL_MASK, v & IMPL_MASK);
      chk6(din, 6'h00);
      // Inputs: random levels against random analog-select
      apb(1'b1, OFF_DIR, 32'h3F);
      ext_en <= 6'h3F;
      for (i = 0; i < 6; i++) begin
         a = 6'($random(seed));
         ext_val <= 6'($random(seed));
         apb(1'b1, OFF_ANSEL, {26'h0, a});
         settle(5);
         chk6(din, pin_exp(ext_val, a));
         apb(1'b0, OFF_PIN, 32'h0);
         chk(rd, {26'h0, pin_exp(ext_val, a)});
      end
      // Pin three pull-up from the strap or its own bit
      apb(1'b1, OFF_WPU, 32'h0);
      strap <= 1'b1;
      settle(5);
      chk6(pad_pullup & PIN3_MASK, PIN3_MASK);
      // Pin three reads high while it serves as the reset input
      apb(1'b0, OFF_PIN, 32'h0);
      chk(rd, {26'h0, pin_exp(ext_val, a) | PIN3_MASK});
      strap <= 1'b0;
      settle(5);
      chk6(pad_pullup & PIN3_MASK, 6'h00);
      apb(1'b1, OFF_WPU, {26'h0, PIN3_MASK});
      settle(2);
      chk6(pad_pullup & PIN3_MASK, PIN3_MASK);
      // Open drain on pin five, push-pull on pin zero
      ext_en <= PIN3_MASK;
      apb(1'b1, OFF_ANSEL, 32'h0);
      apb(1'b1, OFF_DIR, 32'h0);
      apb(1'b1, OFF_ODC, 32'h20);
      apb(1'b1, OFF_WPU, 32'h21);
      apb(1'b1, OFF_LAT, 32'h20);
      settle(2);
      chk6(pad_oe_n & 6'h21, 6'h20);
      chk6(pad_pullup & 6'h21, 6'h20);
      apb(1'b1, OFF_LAT, 32'h00);
      settle(2);
      chk6(pad_oe_n & 6'h21, 6'h00);
      chk6(pad_pullup & 6'h21, 6'h00);
      // A write without the low byte strobe leaves the latch alone
      strb <= 4'hE;
      apb(1'b1, OFF_LAT, 32'h3F);
      strb <= 4'hF;
      apb(1'b0, OFF_LAT, 32'h0);
      chk(rd, 32'h0);
      // Peripheral ownership, I2C drain and analog output
      apb(1'b1, OFF_ODC, 32'h0);
      p_en <= 6'h03;
      p_out <= 6'h03;
      p_od <= 6'h02;
      a_out <= 6'h04;
      settle(5);
      chk6(pad_oe_n, 6'h0E);
      chk6(pad_out & 6'h01, 6'h01);
      chk6(din & 6'h01, 6'h01);
      // Thresholds change only with peripherals released
      {p_en, p_out, p_od, a_out} <= '0;
      v = 6'($random(seed));
      apb(1'b1, OFF_SLEW, {26'h0, v});
      apb(1'b1, OFF_INLVL, {26'h0, ~v});
      settle(2);
      chk6(slew, v & IMPL_MASK);
      chk6(schm, ~v);
      // Second reset in mid-run brings back the reset values
      presetn <= 1'b0;
      settle(3);
      presetn <= 1'b1;
      chk6(pad_oe_n, 6'h3F);
      chk6(slew, RST_SLEW);
      apb(1'b0, OFF_LAT, 32'h0);
      chk(rd, {26'h0, RST_LAT});
      apb(1'b0, OFF_ANSEL, 32'h0);
      chk(rd, {26'h0, RST_ANSEL});
      // Unmapped address
      apb(1'b1, 8'h20, 32'hFFFFFFFF);
      chk({31'h0, er}, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, er}, 32'h1);
      end_sim();
   end
endmodule // tb_top
